// file: rtl/sadc_top.sv
// Digital sequencer of an 8-channel 10-bit serial successive-approximation converter.
// Assumes the serial pins arrive asynchronously; analog switches and comparator are outside.
`timescale 1ns/10ps
`include "sadc_cfg.svh"
module sadc_top #(
    parameter int INT_STEP_CYCLES = `SADC_INT_STEP_CYCLES,
    parameter int FIFO_DEPTH = `SADC_FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic serial_clock,
    input wire logic chip_select_n,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_out_oe_n,
    output logic conversion_strobe,
    output logic conversion_strobe_oe_n,
    input wire logic comparator_above,
    input wire logic shutdown_is_low,
    input wire logic shutdown_is_high,
    output logic [2:0] pos_node_sel,
    output logic [2:0] neg_node_sel,
    output logic neg_to_common,
    output logic track_enable,
    output logic hold_to_negative,
    output logic [9:0] dac_code,
    output logic polarity_bipolar,
    output logic powered_down,
    output logic fast_power_down,
    output logic ref_internal_comp,
    output logic result_valid,
    output logic [12:0] result_data,
    input wire logic result_ready
);
    localparam int NSYNC = 6;
    localparam logic [NSYNC-1:0] SYNC_IDLE = 6'h11; // Pin idle levels, so reset leaves no false edge or select
    localparam logic [3:0] LAST_IDX = 4'(`SADC_RESULT_BITS - 1);
    localparam logic [3:0] CTRL_BITS = 4'(`SADC_CTRL_BITS);
    localparam logic [3:0] TRACK_BIT = 4'(`SADC_TRACK_AFTER_BIT);
    localparam logic [15:0] STEP_LOAD = 16'(INT_STEP_CYCLES - 1);

    // Two-stage synchronisers for every asynchronous input
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    assign raw_in = {serial_clock, chip_select_n, serial_data_in, comparator_above, shutdown_is_low,
                     shutdown_is_high};
    generate
        for (genvar i = 0; i < NSYNC; i++) begin : g_sync
            always_ff @(posedge sys_clk) begin
                if (!reset_n) begin
                    sync_a[i] <= SYNC_IDLE[i];
                    sync_b[i] <= SYNC_IDLE[i];
                end else begin
                    sync_a[i] <= raw_in[i];
                    sync_b[i] <= sync_a[i];
                end
            end
        end
    endgenerate

    logic s_sclk;
    logic s_cs_n;
    logic s_din;
    logic s_comp;
    logic s_three_level_shutdown_low;
    logic s_three_level_shutdown_high;
    assign {s_sclk, s_cs_n, s_din, s_comp, s_three_level_shutdown_low, s_three_level_shutdown_high} = sync_b;

    sadc_stream_if #(.WIDTH(`SADC_FIFO_WIDTH)) fill_bus ();
    sadc_stream_if #(.WIDTH(`SADC_FIFO_WIDTH)) drain_bus ();

    sadc_fifo #(.WIDTH(`SADC_FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .fill(fill_bus),
        .drain(drain_bus)
    );

    sadc_pkg::sadc_state_t state, next_state;
    sadc_pkg::sadc_pmode_t mode, next_mode;
    logic sclk_prev, next_sclk_prev;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] ctrl, next_ctrl;
    logic [3:0] bit_idx, next_bit_idx;
    logic [15:0] step_cnt, next_step_cnt;
    logic [9:0] out_shift, next_out_shift;
    logic [2:0] chan, next_chan;
    logic push_valid, next_push_valid;
    logic [12:0] push_data, next_push_data;
    logic next_dout, next_dout_oe_n, next_strobe, next_strobe_oe_n;
    logic [2:0] next_pos, next_neg;
    logic next_neg_common, next_track, next_hold_neg, next_bipolar;
    logic [9:0] next_code;
    logic next_pd, next_fast_pd, next_ref_int;
    logic next_res_valid;
    logic [12:0] next_res_data;
    logic sclk_rise, sclk_fall, cs_active, decide, keep, done;
    logic [7:0] byte_in;

    assign fill_bus.valid = push_valid;
    assign fill_bus.data = push_data;

    always_comb begin
        next_state = state;
        next_mode = mode;
        next_sclk_prev = s_sclk;
        next_bit_cnt = bit_cnt;
        next_ctrl = ctrl;
        next_bit_idx = bit_idx;
        next_step_cnt = step_cnt;
        next_out_shift = out_shift;
        next_chan = chan;
        next_push_valid = 1'b0;
        next_push_data = push_data;
        next_dout = serial_data_out;
        next_strobe = conversion_strobe;
        next_pos = pos_node_sel;
        next_neg = neg_node_sel;
        next_neg_common = neg_to_common;
        next_track = track_enable;
        next_hold_neg = hold_to_negative;
        next_code = dac_code;
        next_bipolar = polarity_bipolar;
        next_pd = powered_down;
        next_fast_pd = fast_power_down;
        next_ref_int = s_three_level_shutdown_high;
        sclk_rise = s_sclk & ~sclk_prev;
        sclk_fall = ~s_sclk & sclk_prev;
        cs_active = ~s_cs_n;
        decide = 1'b0;
        keep = s_comp;
        done = 1'b0;
        byte_in = {ctrl[6:0], s_din};
        drain_bus.ready = 1'b0;
        next_res_valid = result_valid;
        next_res_data = result_data;

        // Serial output shifts on falling edges only, while selected
        if (sclk_fall && cs_active) begin
            next_dout = out_shift[9];
            next_out_shift = {out_shift[8:0], 1'b0};
        end

        if (s_three_level_shutdown_low) begin
            next_state = sadc_pkg::SADC_IDLE;
            next_bit_cnt = 4'h0;
            next_track = 1'b0;
            next_hold_neg = 1'b0;
            next_strobe = 1'b1;
        end else begin
            case (state)
                sadc_pkg::SADC_IDLE: begin
                    next_bit_cnt = 4'h0;
                    if (cs_active && sclk_rise && s_din) begin
                        next_state = sadc_pkg::SADC_RECV;
                        next_ctrl = {7'h00, 1'b1};
                        next_bit_cnt = 4'h1;
                        next_pd = 1'b0;
                        next_fast_pd = 1'b0;
                    end
                end
                sadc_pkg::SADC_RECV: begin
                    if (!cs_active) begin
                        next_state = sadc_pkg::SADC_IDLE;
                        next_bit_cnt = 4'h0;
                    end else if (sclk_rise && bit_cnt < CTRL_BITS) begin
                        next_ctrl = byte_in;
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (sclk_fall && bit_cnt == TRACK_BIT) begin
                        next_track = 1'b1;
                        next_hold_neg = 1'b0;
                    end else if (sclk_fall && bit_cnt == CTRL_BITS) begin
                        next_track = 1'b0;
                        next_bit_cnt = 4'h0;
                        next_mode = sadc_pkg::sadc_pmode_t'(ctrl[`SADC_PM_HI:`SADC_PM_LO]);
                        next_chan = {ctrl[`SADC_SEL_MID], ctrl[`SADC_SEL_LO], ctrl[`SADC_SEL_HI]};
                        next_bipolar = ~ctrl[`SADC_POL_BIT];
                        next_pos = {ctrl[`SADC_SEL_MID], ctrl[`SADC_SEL_LO], ctrl[`SADC_SEL_HI]};
                        next_neg = {ctrl[`SADC_SEL_MID], ctrl[`SADC_SEL_LO], ~ctrl[`SADC_SEL_HI]};
                        next_neg_common = ctrl[`SADC_TOPO_BIT];
                        next_code = `SADC_MSB_TRIAL;
                        next_bit_idx = LAST_IDX;
                        next_step_cnt = STEP_LOAD;
                        next_state = sadc_pkg::SADC_IDLE;
                        if (!ctrl[`SADC_PM_HI]) begin
                            next_pd = 1'b1;
                            next_fast_pd = ctrl[`SADC_PM_LO];
                            next_track = 1'b1;
                        end else if (!fill_bus.ready) begin
                            next_track = 1'b1;
                        end else if (ctrl[`SADC_PM_LO]) begin
                            next_state = sadc_pkg::SADC_STRB;
                            next_strobe = 1'b1;
                            next_hold_neg = 1'b1;
                        end else begin
                            next_state = sadc_pkg::SADC_CONV;
                            next_strobe = 1'b0;
                            next_hold_neg = 1'b1;
                        end
                    end
                end
                sadc_pkg::SADC_STRB: begin
                    if (!cs_active) begin
                        next_state = sadc_pkg::SADC_IDLE;
                        next_hold_neg = 1'b0;
                        next_track = 1'b1;
                    end else if (sclk_fall) begin
                        next_strobe = 1'b0;
                        next_state = sadc_pkg::SADC_CONV;
                        decide = 1'b1;
                    end
                end
                sadc_pkg::SADC_CONV: begin
                    if (mode == sadc_pkg::SADC_PM_EXT) begin
                        if (!cs_active) begin
                            next_state = sadc_pkg::SADC_IDLE;
                            next_hold_neg = 1'b0;
                            next_track = 1'b1;
                        end else if (sclk_fall) begin
                            decide = 1'b1;
                        end
                    end else if (step_cnt == 16'h0000) begin
                        decide = 1'b1;
                        next_step_cnt = STEP_LOAD;
                    end else begin
                        next_step_cnt = step_cnt - 16'h0001;
                    end
                end
                default: begin
                    next_state = sadc_pkg::SADC_IDLE;
                end
            endcase
        end

        // One successive-approximation decision
        if (decide) begin
            next_code[bit_idx] = keep;
            if (bit_idx != 4'h0) begin
                next_code[bit_idx - 4'h1] = 1'b1;
                next_bit_idx = bit_idx - 4'h1;
            end else begin
                done = 1'b1;
            end
            if (mode == sadc_pkg::SADC_PM_EXT) begin
                next_dout = keep;
                next_out_shift = 10'h000;
            end
        end
        if (done) begin
            next_state = sadc_pkg::SADC_IDLE;
            next_hold_neg = 1'b0;
            next_track = 1'b1;
            next_push_valid = 1'b1;
            next_push_data = {chan, next_code};
            if (mode != sadc_pkg::SADC_PM_EXT) begin
                next_strobe = 1'b1;
                next_out_shift = next_code;
            end
        end

        next_dout_oe_n = s_cs_n | s_three_level_shutdown_low;
        next_strobe_oe_n = s_three_level_shutdown_low | ((next_mode == sadc_pkg::SADC_PM_EXT) & s_cs_n);

        // Registered result stream toward the user side
        if (!result_valid || result_ready) begin
            next_res_valid = drain_bus.valid;
            drain_bus.ready = drain_bus.valid;
            if (drain_bus.valid) begin
                next_res_data = drain_bus.data;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state <= sadc_pkg::SADC_IDLE;
            mode <= sadc_pkg::SADC_PM_FULL_PD;
            sclk_prev <= 1'b0;
            bit_cnt <= 4'h0;
            ctrl <= `SADC_RST_CTRL;
            bit_idx <= 4'h0;
            step_cnt <= 16'h0000;
            out_shift <= `SADC_RST_CODE;
            chan <= 3'h0;
            push_valid <= 1'b0;
            push_data <= 13'h0000;
            serial_data_out <= 1'b0;
            serial_data_out_oe_n <= 1'b1;
            conversion_strobe <= 1'b1;
            conversion_strobe_oe_n <= 1'b1;
            pos_node_sel <= 3'h0;
            neg_node_sel <= 3'h0;
            neg_to_common <= 1'b1;
            track_enable <= 1'b0;
            hold_to_negative <= 1'b0;
            dac_code <= `SADC_RST_CODE;
            polarity_bipolar <= 1'b0;
            powered_down <= 1'b0;
            fast_power_down <= 1'b0;
            ref_internal_comp <= 1'b0;
            result_valid <= 1'b0;
            result_data <= 13'h0000;
        end else begin
            state <= next_state;
            mode <= next_mode;
            sclk_prev <= next_sclk_prev;
            bit_cnt <= next_bit_cnt;
            ctrl <= next_ctrl;
            bit_idx <= next_bit_idx;
            step_cnt <= next_step_cnt;
            out_shift <= next_out_shift;
            chan <= next_chan;
            push_valid <= next_push_valid;
            push_data <= next_push_data;
            serial_data_out <= next_dout;
            serial_data_out_oe_n <= next_dout_oe_n;
            conversion_strobe <= next_strobe;
            conversion_strobe_oe_n <= next_strobe_oe_n;
            pos_node_sel <= next_pos;
            neg_node_sel <= next_neg;
            neg_to_common <= next_neg_common;
            track_enable <= next_track;
            hold_to_negative <= next_hold_neg;
            dac_code <= next_code;
            polarity_bipolar <= next_bipolar;
            powered_down <= next_pd | s_three_level_shutdown_low;
            fast_power_down <= next_fast_pd;
            ref_internal_comp <= next_ref_int;
            result_valid <= next_res_valid;
            result_data <= next_res_data;
        end
    end
endmodule : sadc_top

// file: rtl/sadc_cfg.svh
// Constants of the serial converter sequencer: control-byte fields, counts, timing.
// Assumes inclusion by bare name from files that need these macros.
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH

`define SADC_CTRL_BITS 8
`define SADC_RESULT_BITS 10
`define SADC_TRACK_AFTER_BIT 5
`define SADC_SEL_HI 6
`define SADC_SEL_MID 5
`define SADC_SEL_LO 4
`define SADC_POL_BIT 3
`define SADC_TOPO_BIT 2
`define SADC_PM_HI 1
`define SADC_PM_LO 0
`define SADC_CLK_PERIOD_NS 25
`define SADC_INT_STEP_NS 500
`define SADC_INT_STEP_CYCLES ((`SADC_INT_STEP_NS + `SADC_CLK_PERIOD_NS - 1) / `SADC_CLK_PERIOD_NS)
`define SADC_FIFO_DEPTH 16
`define SADC_FIFO_WIDTH 13
`define SADC_RST_CODE 10'h000
`define SADC_RST_CTRL 8'h00
`define SADC_MSB_TRIAL 10'h200

`endif

// file: rtl/sadc_pkg.sv
// Types shared by the serial converter sequencer files.
// Assumes sadc_cfg.svh supplies the numeric constants.
package sadc_pkg;

    typedef enum logic [1:0] {
        SADC_IDLE = 2'h0,
        SADC_RECV = 2'h1,
        SADC_STRB = 2'h3,
        SADC_CONV = 2'h2
    } sadc_state_t;

    typedef enum logic [1:0] {
        SADC_PM_FULL_PD = 2'h0,
        SADC_PM_FAST_PD = 2'h1,
        SADC_PM_INT = 2'h2,
        SADC_PM_EXT = 2'h3
    } sadc_pmode_t;

endpackage : sadc_pkg

// file: rtl/sadc_stream_if.sv
// Valid/ready word stream between the sequencer and its result FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface sadc_stream_if #(parameter int WIDTH = 13) ();
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sadc_stream_if

// file: rtl/sadc_fifo.sv
// Result FIFO, flip-flop storage, parameterised width and depth.
// Assumes synchronous active-low reset; DEPTH a power of two.
`timescale 1ns/10ps
module sadc_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    sadc_stream_if.snk fill,
    sadc_stream_if.src drain
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] next_wr_ptr;
    logic [AW:0] next_rd_ptr;
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign empty = (wr_ptr == rd_ptr);
    assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign fill.ready = ~full;
    assign drain.valid = ~empty;
    assign drain.data = mem[rd_ptr[AW-1:0]];
    assign push = fill.valid & ~full;
    assign pop = drain.ready & ~empty;

    always_comb begin
        next_mem = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (push) begin
            next_mem[wr_ptr[AW-1:0]] = fill.data;
            next_wr_ptr = wr_ptr + {{AW{1'b0}}, 1'b1};
        end
        if (pop) begin
            next_rd_ptr = rd_ptr + {{AW{1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge sys_clk) begin
        mem <= next_mem;
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end
endmodule : sadc_fifo

// file: dv/sadc_top_assertions.sv
// Port checker of the converter sequencer: serial pins, strobe, track/hold, result stream.
// Assumes sys_clk samples the asynchronous serial pins; bound into every sadc_top.
`timescale 1ns/10ps
module sadc_top_checker #(
    parameter int INT_STEP_CYCLES = 20,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic serial_clock,
    input wire logic chip_select_n,
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe_n,
    input wire logic conversion_strobe,
    input wire logic conversion_strobe_oe_n,
    input wire logic shutdown_is_low,
    input wire logic shutdown_is_high,
    input wire logic [2:0] pos_node_sel,
    input wire logic [2:0] neg_node_sel,
    input wire logic neg_to_common,
    input wire logic track_enable,
    input wire logic hold_to_negative,
    input wire logic [9:0] dac_code,
    input wire logic powered_down,
    input wire logic ref_internal_comp,
    input wire logic result_valid,
    input wire logic [12:0] result_data,
    input wire logic result_ready
);
    localparam int INT_MAX = 10 * INT_STEP_CYCLES + 40;
    logic sclk_q;
    logic [3:0] fall_age;
    // Cycles since the last serial clock fall, saturating
    always_ff @(posedge sys_clk) begin
        sclk_q <= serial_clock;
        if (!reset_n) fall_age <= 4'hf;
        else if (sclk_q && !serial_clock) fall_age <= 4'h0;
        else if (fall_age != 4'hf) fall_age <= fall_age + 4'h1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence ext_begin;
        $rose(hold_to_negative) && conversion_strobe;
    endsequence
    sequence int_begin;
        $rose(hold_to_negative) && !conversion_strobe;
    endsequence
    chk_dout_edge: assert property (!serial_data_out_oe_n && $changed(serial_data_out) |-> fall_age <= 4'h6)
        else $error("data output moved away from a serial clock fall");
    chk_dout_float: assert property (chip_select_n [*5] |-> serial_data_out_oe_n)
        else $error("data output driven while deselected");
    chk_three_level_shutdown_quiet: assert property (shutdown_is_low [*5] |-> serial_data_out_oe_n && conversion_strobe_oe_n && powered_down)
        else $error("outputs active during shutdown");
    chk_comp_mode: assert property ((!shutdown_is_low && $stable(shutdown_is_high)) [*6] |-> ref_internal_comp == shutdown_is_high)
        else $error("compensation mode does not follow shutdown pin");
    chk_hold_start: assert property ($rose(hold_to_negative) |-> dac_code == 10'h200 && !track_enable)
        else $error("conversion did not start from the middle trial in hold");
    chk_track_back: assert property ($fell(hold_to_negative) |-> track_enable)
        else $error("positive node not reconnected at conversion end");
    chk_ext_pulse: assert property (ext_begin |-> conversion_strobe [*8] ##1 !conversion_strobe)
        else $error("external strobe pulse is not one serial period");
    chk_int_low: assert property (int_begin |-> !conversion_strobe until (conversion_strobe && !hold_to_negative))
        else $error("internal strobe rose before conversion end");
    chk_int_end: assert property (int_begin |-> ##[1:INT_MAX] conversion_strobe)
        else $error("internal conversion did not finish");
    chk_diff_pair: assert property (!neg_to_common |-> neg_node_sel == (pos_node_sel ^ 3'h1))
        else $error("differential nodes not an adjacent pair");
    chk_result_hold: assert property (result_valid && !result_ready |=> result_valid && $stable(result_data))
        else $error("result word dropped before acceptance");
endmodule : sadc_top_checker
bind sadc_top sadc_top_checker #(.INT_STEP_CYCLES(INT_STEP_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) i_sadc_top_checker (.*);

// file: dv/sadc_host_model.sv
// Host side of the four-wire serial link: chip select, serial clock, data in, data out capture.
// Assumes the bench calls its tasks; sys_clk paces every edge; clock idles low between frames.
`timescale 1ns/10ps
module sadc_host_model (
    input wire logic sys_clk,
    input wire logic serial_data_out,
    output logic serial_clock,
    output logic chip_select_n,
    output logic serial_data_in
);
    initial begin
        serial_clock = 1'h0;
        chip_select_n = 1'h1;
        serial_data_in = 1'h0;
    end
    task automatic select(input logic on);
        @(posedge sys_clk);
        chip_select_n <= !on;
        if (!on) begin
            serial_data_in <= !serial_data_in;
        end
    endtask : select
    // Sends n bits from the top of bits; each sample is taken just before its clock falls
    task automatic clocks(input logic [23:0] bits, input int n, input logic ctl, output logic [23:0] rx);
        int half;
        rx = 24'h00_0000;
        for (int j = 0; j < n; j++) begin
            half = (ctl && j >= 5 && j < 8) ? 12 : 4;
            @(posedge sys_clk);
            serial_data_in <= bits[23 - j];
            repeat (half - 1) @(posedge sys_clk);
            serial_clock <= 1'h1;
            repeat (half) @(posedge sys_clk);
            rx = {rx[22:0], serial_data_out};
            serial_clock <= 1'h0;
        end
    endtask : clocks
endmodule : sadc_host_model

// file: dv/sadc_top_bench.sv
// Self-checking bench of the converter sequencer: host model, comparator stand-in, result reader.
// Assumes a 40 MHz system clock and a 200 ns serial clock made by the host model, 600 ns on bits six to eight of a control frame.
`timescale 1ns/10ps
module sadc_top_bench;
    logic sys_clk, reset_n, serial_clock, chip_select_n, serial_data_in, serial_data_out, serial_data_out_oe_n;
    logic conversion_strobe, conversion_strobe_oe_n, comparator_above, shutdown_is_low, shutdown_is_high;
    logic neg_to_common, track_enable, hold_to_negative, polarity_bipolar, powered_down, fast_power_down;
    logic ref_internal_comp, result_valid, result_ready;
    logic [2:0] pos_node_sel, neg_node_sel, ch;
    logic [9:0] dac_code, level, lvl;
    logic [12:0] result_data;
    logic [12:0] expect_q [$];
    logic [23:0] rx;
    logic [7:0] ctl;
    int miscompares, samples_checked;

    sadc_top #(.INT_STEP_CYCLES(4)) i_sadc_top (.*);
    sadc_host_model i_sadc_host_model (.*);
    // Comparator keeps a trial bit while the input is at or above the trial code
    assign comparator_above = dac_code <= level;

    initial begin
        sys_clk = 1'h0;
        forever #12.5 sys_clk = !sys_clk;
    end
    task automatic check(input string what, input logic [12:0] exp, input logic [12:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic conclude();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    task automatic wait_high(input int which, input int limit);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (n > limit) begin
                miscompares++;
                conclude();
            end
        end while ((which == 0 ? conversion_strobe : result_valid) !== 1'h1);
    endtask : wait_high
    task automatic ext_conv(input logic [7:0] c, input int lead, input logic [9:0] v);
        level <= v;
        i_sadc_host_model.select(1'h1);
        i_sadc_host_model.clocks(24'h00_0000, lead, 1'h0, rx);
        i_sadc_host_model.clocks({c, 16'h0000}, 24, 1'h1, rx);
        i_sadc_host_model.select(1'h0);
    endtask : ext_conv
    task automatic check_code(input logic [9:0] v);
        check("result bits", {3'h0, v}, {3'h0, rx[14:5]});
        check("trailing bits", 13'h0000, {8'h00, rx[4:0]});
    endtask : check_code

    initial begin
        reset_n = 1'h0;
        shutdown_is_low = 1'h0;
        shutdown_is_high = 1'h1;
        result_ready = 1'h0;
        level = 10'h000;
        miscompares = 0;
        samples_checked = 0;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'h1;
        repeat (4) @(posedge sys_clk);
        // Seventeen conversions fill output register and FIFO, the eighteenth is refused
        for (int i = 0; i < 18; i++) begin
            ctl = {1'h1, i[2:0], i[3], i[0], 2'h3};
            ch = {i[1], i[0], i[2]};
            lvl = 10'(i * 61 + 7);
            ext_conv(ctl, i % 3, lvl);
            if (i < 17) begin
                expect_q.push_back({ch, lvl});
                check_code(lvl);
                check("positive node", {10'h000, ch}, {10'h000, pos_node_sel});
                check("common return", {12'h000, i[0]}, {12'h000, neg_to_common});
                check("polarity", {12'h000, !i[3]}, {12'h000, polarity_bipolar});
            end
        end
        result_ready <= 1'h1;
        foreach (expect_q[k]) begin
            wait_high(1, 40);
            check("fifo word", expect_q[k], result_data);
        end
        result_ready <= 1'h0;
        repeat (3) @(posedge sys_clk);
        check("fifo empty", 13'h0000, {12'h000, result_valid});
        // Internal clock conversion, result read after the strobe rises
        level <= 10'h2a5;
        i_sadc_host_model.select(1'h1);
        i_sadc_host_model.clocks({8'hde, 16'h0000}, 8, 1'h1, rx);
        repeat (6) @(posedge sys_clk);
        check("strobe low", 13'h0000, {12'h000, conversion_strobe});
        wait_high(0, 400);
        i_sadc_host_model.clocks(24'h00_0000, 16, 1'h0, rx);
        i_sadc_host_model.select(1'h0);
        check_code(10'h2a5);
        check("fifo word", {3'h3, 10'h2a5}, result_data);
        result_ready <= 1'h1;
        for (int m = 0; m < 2; m++) begin
            i_sadc_host_model.select(1'h1);
            i_sadc_host_model.clocks({7'h46, m[0], 16'h0000}, 8, 1'h1, rx);
            i_sadc_host_model.select(1'h0);
            repeat (6) @(posedge sys_clk);
            check("power modes", {11'h000, 1'h1, m[0]}, {11'h000, powered_down, fast_power_down});
        end
        // Abort after four bits, clocks while deselected, then a clean frame
        i_sadc_host_model.select(1'h1);
        i_sadc_host_model.clocks(24'hb0_0000, 4, 1'h0, rx);
        i_sadc_host_model.select(1'h0);
        i_sadc_host_model.clocks(24'hff_ffff, 6, 1'h0, rx);
        ext_conv(8'hff, 0, 10'h3c1);
        check_code(10'h3c1);
        repeat (4) @(posedge sys_clk);
        check("strobe float", 13'h0001, {12'h000, conversion_strobe_oe_n});
        result_ready <= 1'h0;
        shutdown_is_low <= 1'h1;
        repeat (6) @(posedge sys_clk);
        check("shutdown", 13'h0007, {10'h000, powered_down, serial_data_out_oe_n, conversion_strobe_oe_n});
        ext_conv(8'hff, 0, 10'h155);
        check("no conversion", 13'h0000, {12'h000, result_valid});
        shutdown_is_low <= 1'h0;
        shutdown_is_high <= 1'h0;
        repeat (6) @(posedge sys_clk);
        check("external comp", 13'h0000, {12'h000, ref_internal_comp});
        shutdown_is_high <= 1'h1;
        repeat (6) @(posedge sys_clk);
        check("internal comp", 13'h0001, {12'h000, ref_internal_comp});
        conclude();
    end
endmodule : sadc_top_bench
